// File: abx_alu.v
// Combinational 8-bit add/AND datapath with flag generation
`include "abx_map.vh"
module abx_alu (
   // Operands
   input wire [7:0] op_a,
   input wire [7:0] op_b,
   input wire sel_and,
   // Result and flags
   output wire [7:0] result,
   output wire carry,
   output wire digit_carry,
   output wire zero
);
   wire [8:0] sum;
   wire [4:0] low_sum;
   assign sum = {1'b0, op_a} + {1'b0, op_b};
   assign low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
   assign result = sel_and ? (op_a & op_b) : sum[7:0];
   assign carry = sum[8];
   assign digit_carry = low_sum[4];
   assign zero = (result == 8'h00);
endmodule // abx_alu

// File: abx_exec.v
// Decode and execute unit for add, AND and bit-oriented instructions
`include "abx_map.vh"
module abx_exec (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Instruction input from fetch
   input wire instr_valid,
   input wire [13:0] instr,
   // File register read port (combinational, addressed by file_raddr)
   output wire [6:0] file_raddr,
   input wire [7:0] file_rdata,
   // File register write port
   output reg file_we_q,
   output reg [6:0] file_waddr_q,
   output reg [7:0] file_wdata_q,
   // Architectural state
   output reg [7:0] acc_q,
   output reg carry_flag_q,
   output reg digit_carry_flag_q,
   output reg zero_flag_q,
   // Skip indication: the current instruction is squashed to a NOP
   output wire skip_nop,
   output reg done_q
);
   wire [5:0] opc6;
   wire [4:0] opc5;
   wire [7:0] lit;
   wire [2:0] bpos;
   wire dest_file;
   wire is_add_lit;
   wire is_and_lit;
   wire is_add_file;
   wire is_and_file;
   wire is_bit_clr;
   wire is_bit_set;
   wire is_bit_tsc;
   wire is_byte_file;
   wire use_lit;
   wire [7:0] alu_b;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_dc;
   wire alu_z;
   wire [7:0] bit_mask;
   wire exec;
   reg skip_q;
   reg skip_d;
   reg dec_add_lit;
   reg dec_and_lit;
   reg dec_add_file;
   reg dec_and_file;
   reg dec_bit_clr;
   reg dec_bit_set;
   reg dec_bit_tsc;
   wire [7:0] bit_res;
   wire tested_bit;
   reg [7:0] acc_d;
   reg carry_flag_d;
   reg digit_carry_flag_d;
   reg zero_flag_d;
   reg file_we_d;
   reg [6:0] file_waddr_d;
   reg [7:0] file_wdata_d;
   reg done_d;
   genvar gi;

   // Skip tracker: a failed bit test arms a squash of the next valid slot
   localparam SK_RUN = 1'b0;
   localparam SK_SQUASH = 1'b1;

   assign opc6 = instr[`ABX_OPC6_HI:`ABX_OPC6_LO];
   assign opc5 = instr[`ABX_OPC5_HI:`ABX_OPC5_LO];
   assign lit = instr[7:0];
   assign bpos = instr[`ABX_BITPOS_HI:`ABX_BITPOS_LO];
   assign dest_file = instr[`ABX_DEST_BIT];

   // A squashed slot executes as a NOP regardless of its opcode
   assign skip_nop = instr_valid & (skip_q == SK_SQUASH);
   assign exec = instr_valid & (skip_q == SK_RUN);

   // Opcode decoder: byte and literal ops match six bits, bit ops five
   always @* begin
      dec_add_lit = 1'b0;
      dec_and_lit = 1'b0;
      dec_add_file = 1'b0;
      dec_and_file = 1'b0;
      dec_bit_clr = 1'b0;
      dec_bit_set = 1'b0;
      dec_bit_tsc = 1'b0;
      case (opc6)
         `ABX_OP_ADD_LIT: begin
            dec_add_lit = 1'b1;
         end
         `ABX_OP_AND_LIT: begin
            dec_and_lit = 1'b1;
         end
         `ABX_OP_ADD_FILE: begin
            dec_add_file = 1'b1;
         end
         `ABX_OP_AND_FILE: begin
            dec_and_file = 1'b1;
         end
         default: begin
            dec_add_lit = 1'b0;
         end
      endcase
      case (opc5)
         `ABX_OP_BIT_CLR: begin
            dec_bit_clr = 1'b1;
         end
         `ABX_OP_BIT_SET: begin
            dec_bit_set = 1'b1;
         end
         `ABX_OP_BIT_TSC: begin
            dec_bit_tsc = 1'b1;
         end
         default: begin
            dec_bit_clr = 1'b0;
         end
      endcase
   end

   // Every decode is gated by exec, so a squashed slot decodes as nothing
   assign is_add_lit = exec & dec_add_lit;
   assign is_and_lit = exec & dec_and_lit;
   assign is_add_file = exec & dec_add_file;
   assign is_and_file = exec & dec_and_file;
   assign is_bit_clr = exec & dec_bit_clr;
   assign is_bit_set = exec & dec_bit_set;
   assign is_bit_tsc = exec & dec_bit_tsc;
   assign is_byte_file = is_add_file | is_and_file;
   assign use_lit = is_add_lit | is_and_lit;

   // Byte ops see 128 file registers, bit ops only the low 64
   assign file_raddr = is_byte_file ? instr[`ABX_FADDR7_HI:0]
                                    : {1'b0, instr[`ABX_FADDR6_HI:0]};

   assign alu_b = use_lit ? lit : file_rdata;
   // One slice per data bit: select and modify work bitwise; the test then reduces the masked byte
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
         assign bit_mask[gi] = (bpos == gi);
         assign bit_res[gi] = bit_mask[gi] ? is_bit_set : file_rdata[gi];
      end
   endgenerate
   assign tested_bit = |(file_rdata & bit_mask);

   abx_alu u_alu (
      .op_a(acc_q),
      .op_b(alu_b),
      .sel_and(is_and_lit | is_and_file),
      .result(alu_res),
      .carry(alu_c),
      .digit_carry(alu_dc),
      .zero(alu_z)
   );

   // Skip tracker next state; idle cycles leave a pending squash armed
   always @* begin
      skip_d = skip_q;
      case (skip_q)
         SK_RUN: begin
            if (is_bit_tsc && !tested_bit) begin
               skip_d = SK_SQUASH;
            end
            // A set bit stays in SK_RUN, so the next slot runs normally
         end
         SK_SQUASH: begin
            // The squashed slot consumes the skip, so it cannot skip again
            if (instr_valid) begin
               skip_d = SK_RUN;
            end
         end
         default: begin
            skip_d = SK_RUN;
         end
      endcase
   end

   // Next architectural state; at most one decode is active per slot
   always @* begin
      acc_d = acc_q;
      carry_flag_d = carry_flag_q;
      digit_carry_flag_d = digit_carry_flag_q;
      zero_flag_d = zero_flag_q;
      file_we_d = 1'b0;
      file_waddr_d = file_waddr_q;
      file_wdata_d = file_wdata_q;
      done_d = instr_valid;
      if (is_add_lit) begin
         acc_d = alu_res;
         carry_flag_d = alu_c;
         digit_carry_flag_d = alu_dc;
         zero_flag_d = alu_z;
      end
      if (is_and_lit) begin
         acc_d = alu_res;
         zero_flag_d = alu_z;
      end
      if (is_add_file) begin
         carry_flag_d = alu_c;
         digit_carry_flag_d = alu_dc;
      end
      if (is_byte_file) begin
         zero_flag_d = alu_z;
         if (dest_file) begin
            file_we_d = 1'b1;
            file_waddr_d = file_raddr;
            file_wdata_d = alu_res;
         end else begin
            acc_d = alu_res;
         end
      end
      // Read-modify-write of one bit; flags stay as they are
      if (is_bit_clr || is_bit_set) begin
         file_we_d = 1'b1;
         file_waddr_d = file_raddr;
         file_wdata_d = bit_res;
      end
   end

   // Writes are registered, so the register file sees them one cycle late
   always @(posedge mclk) begin
      if (!reset_n) begin
         acc_q <= `ABX_ACC_RST;
         carry_flag_q <= `ABX_FLAG_RST;
         digit_carry_flag_q <= `ABX_FLAG_RST;
         zero_flag_q <= `ABX_FLAG_RST;
         file_we_q <= 1'b0;
         file_waddr_q <= `ABX_FADDR_RST;
         file_wdata_q <= `ABX_WDATA_RST;
         skip_q <= SK_RUN;
         done_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         carry_flag_q <= carry_flag_d;
         digit_carry_flag_q <= digit_carry_flag_d;
         zero_flag_q <= zero_flag_d;
         file_we_q <= file_we_d;
         file_waddr_q <= file_waddr_d;
         file_wdata_q <= file_wdata_d;
         skip_q <= skip_d;
         done_q <= done_d;
      end
   end
endmodule // abx_exec

// File: abx_exec_sva.sv
// Assertions for the add/AND/bit execute unit
`include "abx_map.vh"
module abx_exec_sva (
   // Clock and reset
   input logic mclk,
   input logic reset_n,
   // Instruction slot
   input logic instr_valid,
   input logic [13:0] instr,
   // File register ports
   input logic [6:0] file_raddr,
   input logic [7:0] file_rdata,
   input logic file_we_q,
   input logic [6:0] file_waddr_q,
   input logic [7:0] file_wdata_q,
   // Architectural state
   input logic [7:0] acc_q,
   input logic carry_flag_q,
   input logic digit_carry_flag_q,
   input logic zero_flag_q,
   input logic skip_nop,
   input logic done_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire v = instr_valid & ~skip_nop;
   wire al = v & (instr[13:8] == `ABX_OP_ADD_LIT);
   wire af = v & (instr[13:8] == `ABX_OP_ADD_FILE);
   wire nl = v & (instr[13:8] == `ABX_OP_AND_LIT);
   wire nf = v & (instr[13:8] == `ABX_OP_AND_FILE);
   wire bc = v & (instr[13:9] == `ABX_OP_BIT_CLR);
   wire bs = v & (instr[13:9] == `ABX_OP_BIT_SET);
   wire bt = v & (instr[13:9] == `ABX_OP_BIT_TSC);
   // Literal ops carry a one in opcode bit 12, byte file ops a zero
   wire [7:0] opb = instr[12] ? instr[7:0] : file_rdata;
   wire [8:0] sum = acc_q + opb;
   wire hc = {1'b0, acc_q[3:0]} + opb[3:0] > 5'h0f;
   wire [7:0] msk = 8'h01 << instr[8:6];
   wire tb = |(file_rdata & msk);
   chk_add_lit: assert property (al |=> {carry_flag_q, acc_q} == $past(sum))
      else $error("literal add wrong");
   chk_add_dest: assert property (af && instr[7] |=> file_we_q && $stable(acc_q)
      && {carry_flag_q, file_wdata_q} == $past(sum)) else $error("file add wrong");
   chk_and_file: assert property (nf && !instr[7] |=> !file_we_q
      && acc_q == ($past(acc_q) & $past(file_rdata))) else $error("file and wrong");
   chk_half_carry: assert property (al || af |=> digit_carry_flag_q == $past(hc))
      else $error("digit carry wrong");
   chk_zero_flag: assert property (al || nl |=> zero_flag_q == (acc_q == 8'h00))
      else $error("zero flag wrong");
   chk_and_lit: assert property (nl |=> acc_q == ($past(acc_q) & $past(opb))
      && $stable(carry_flag_q)) else $error("literal and wrong");
   chk_bit_clr: assert property (bc |=> file_we_q && $stable(zero_flag_q)
      && file_wdata_q == ($past(file_rdata) & ~$past(msk))) else $error("bit clear wrong");
   chk_bit_set: assert property (bs |=> file_we_q
      && file_wdata_q == ($past(file_rdata) | $past(msk))) else $error("bit set wrong");
   chk_skip_set: assert property (bt && tb |=> !skip_nop) else $error("bad skip");
   chk_skip_clear: assert property (bt && !tb |=> (instr_valid |-> skip_nop))
      else $error("missing skip");
   chk_squash_idle: assert property (skip_nop |=> !file_we_q && $stable(acc_q)
      && $stable(zero_flag_q) && $stable(carry_flag_q)) else $error("squash changed state");
   chk_bit_addr: assert property (bc || bs || bt |-> file_raddr == {1'b0, instr[5:0]})
      else $error("bit address wrong");
   cover property (bt && !tb);
   cover property (af && instr[7]);
   cover property (al && sum[8]);
endmodule // abx_exec_sva
bind abx_exec abx_exec_sva i_sva (
   .mclk(mclk),
   .reset_n(reset_n),
   .instr_valid(instr_valid),
   .instr(instr),
   .file_raddr(file_raddr),
   .file_rdata(file_rdata),
   .file_we_q(file_we_q),
   .file_waddr_q(file_waddr_q),
   .file_wdata_q(file_wdata_q),
   .acc_q(acc_q),
   .carry_flag_q(carry_flag_q),
   .digit_carry_flag_q(digit_carry_flag_q),
   .zero_flag_q(zero_flag_q),
   .skip_nop(skip_nop),
   .done_q(done_q)
);

// File: abx_exec_tb.sv
// Self-checking bench for the add/AND/bit execute unit
`include "abx_map.vh"
module abx_exec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, reset_n = 0, instr_valid = 0, sk;
   logic [6:0] ra;
   logic [13:0] instr = 14'h0000;
   logic [7:0] file_rdata = 8'h00;
   wire [6:0] file_raddr, file_waddr_q;
   wire [7:0] file_wdata_q, acc_q;
   wire file_we_q, carry_flag_q, digit_carry_flag_q, zero_flag_q, skip_nop, done_q;
   int bad_count = 0, num_checks = 0;
   abx_exec i_dut (
      .mclk(mclk),
      .reset_n(reset_n),
      .instr_valid(instr_valid),
      .instr(instr),
      .file_raddr(file_raddr),
      .file_rdata(file_rdata),
      .file_we_q(file_we_q),
      .file_waddr_q(file_waddr_q),
      .file_wdata_q(file_wdata_q),
      .acc_q(acc_q),
      .carry_flag_q(carry_flag_q),
      .digit_carry_flag_q(digit_carry_flag_q),
      .zero_flag_q(zero_flag_q),
      .skip_nop(skip_nop),
      .done_q(done_q)
   );
   initial forever #5 mclk = ~mclk;
   task complete_run;
      if (bad_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task cmp(input string n, input [15:0] e, g);
      num_checks++;
      if (e !== g) begin
         bad_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task st(input [11:0] e);
      cmp("state", e, {done_q, carry_flag_q, digit_carry_flag_q, zero_flag_q, acc_q});
   endtask
   task wr(input [15:0] e);
      cmp("write", e, {file_we_q, file_waddr_q, file_wdata_q});
   endtask
   task ad(input [6:0] e);
      cmp("raddr", e, ra);
   endtask
   // One slot, then an idle cycle: pending skip must survive the gap
   task op(input [13:0] i, input [7:0] fd);
      @(posedge mclk);
      instr <= i;
      file_rdata <= fd;
      instr_valid <= 1'b1;
      #1 sk = skip_nop;
      ra = file_raddr;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
   endtask
   task t_add;
      op({`ABX_OP_ADD_LIT, 8'hf8}, 8'h00);
      st(12'h8f8);
      op({`ABX_OP_ADD_LIT, 8'h19}, 8'h00);
      st(12'he11);
      op({`ABX_OP_ADD_FILE, 8'h12}, 8'hef);
      st(12'hf00);
      ad(7'h12);
      wr(16'h0000);
      op({`ABX_OP_ADD_FILE, 8'hd5}, 8'h01);
      st(12'h800);
      ad(7'h55);
      wr(16'hd501);
   endtask
   task t_and;
      op({`ABX_OP_ADD_LIT, 8'ha3}, 8'h00);
      op({`ABX_OP_AND_LIT, 8'h5f}, 8'h00);
      st(12'h803);
      op({`ABX_OP_AND_FILE, 8'h90}, 8'hfc);
      st(12'h903);
      wr(16'h9000);
      op({`ABX_OP_AND_FILE, 8'h10}, 8'h02);
      st(12'h802);
      wr(16'h1000);
   endtask
   // Position bits overlap the byte address field, so the bit address must mask them
   task t_bit;
      op({`ABX_OP_BIT_CLR, 3'd7, 6'h3f}, 8'hc7);
      st(12'h802);
      ad(7'h3f);
      wr(16'hbf47);
      op({`ABX_OP_BIT_SET, 3'd7, 6'h01}, 8'h0a);
      st(12'h802);
      ad(7'h01);
      wr(16'h818a);
   endtask
   task t_skip;
      op({`ABX_OP_BIT_TSC, 3'd1, 6'h05}, 8'h02);
      ad(7'h05);
      op({`ABX_OP_ADD_LIT, 8'h01}, 8'h00);
      st(12'h803);
      cmp("skip", 0, sk);
      op({`ABX_OP_BIT_TSC, 3'd0, 6'h05}, 8'h02);
      op({`ABX_OP_ADD_LIT, 8'h01}, 8'h00);
      st(12'h803);
      cmp("skip", 1, sk);
      op({`ABX_OP_ADD_LIT, 8'h01}, 8'h00);
      st(12'h804);
      cmp("skip", 0, sk);
   endtask
   // Test and squashed slot in consecutive cycles, with no idle gap
   task t_b2b;
      @(posedge mclk);
      instr <= {`ABX_OP_BIT_TSC, 3'd3, 6'h22};
      file_rdata <= 8'hf7;
      instr_valid <= 1'b1;
      @(posedge mclk);
      instr <= {`ABX_OP_ADD_LIT, 8'h10};
      #1 cmp("skip", 1, skip_nop);
      @(posedge mclk);
      #1 cmp("skip", 0, skip_nop);
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1 st(12'h814);
   endtask
   // A squash armed before a mid-run reset must not hit the first slot after it
   task t_rst;
      op({`ABX_OP_BIT_TSC, 3'd0, 6'h05}, 8'h00);
      @(posedge mclk);
      reset_n <= 1'b0;
      @(posedge mclk);
      reset_n <= 1'b1;
      #1 st(12'h000);
      wr(16'h0000);
      op({`ABX_OP_ADD_LIT, 8'h80}, 8'h00);
      cmp("skip", 0, sk);
      st(12'h880);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      #1 st(12'h000);
      t_add;
      t_and;
      t_bit;
      t_skip;
      t_b2b;
      t_rst;
      complete_run;
   end
endmodule // abx_exec_tb

// File: abx_map.vh
// Opcode encodings, field positions and reset values for the add/AND/bit execute unit
`ifndef ABX_MAP_VH
`define ABX_MAP_VH
`define ABX_OP_ADD_LIT 6'h1c
`define ABX_OP_AND_LIT 6'h1b
`define ABX_OP_ADD_FILE 6'h07
`define ABX_OP_AND_FILE 6'h05
`define ABX_OP_BIT_CLR 5'h08
`define ABX_OP_BIT_SET 5'h09
`define ABX_OP_BIT_TSC 5'h0a
`define ABX_OPC6_HI 13
`define ABX_OPC6_LO 8
`define ABX_OPC5_HI 13
`define ABX_OPC5_LO 9
`define ABX_DEST_BIT 7
`define ABX_FADDR7_HI 6
`define ABX_FADDR6_HI 5
`define ABX_BITPOS_HI 8
`define ABX_BITPOS_LO 6
`define ABX_ACC_RST 8'h00
`define ABX_FLAG_RST 1'b0
`define ABX_FADDR_RST 7'h00
`define ABX_WDATA_RST 8'h00
`endif
